// ### rtl/sfm_cfg.svh
// Opcodes, array geometry, dummy counts and reset values of the flash front end.
// Included by the design files; holds definitions only.
`ifndef SFM_CFG_SVH
`define SFM_CFG_SVH
`define SFM_OP_NONE       8'h00
`define SFM_OP_WR_ENABLE  8'h06
`define SFM_OP_WR_DISABLE 8'h04
`define SFM_OP_STAT_WRITE 8'h01
`define SFM_OP_PAGE_PROG  8'h02
`define SFM_OP_QUAD_PROG  8'h32
`define SFM_OP_SECT_ERASE 8'h20
`define SFM_OP_B32_ERASE  8'h52
`define SFM_OP_B64_ERASE  8'hD8
`define SFM_OP_CHIP_ER_A  8'h60
`define SFM_OP_CHIP_ER_B  8'hC7
`define SFM_OP_READ       8'h03
`define SFM_OP_FAST_READ  8'h0B
`define SFM_OP_DUAL_OUT   8'h3B
`define SFM_OP_QUAD_OUT   8'h6B
`define SFM_OP_DUAL_IO    8'hBB
`define SFM_OP_QUAD_IO    8'hEB
`define SFM_OP_FOUR_ON    8'h38
`define SFM_OP_FOUR_OFF   8'hFF
`define SFM_OP_PWR_DOWN   8'hB9
`define SFM_OP_PWR_UP     8'hAB
`define SFM_OP_RST_ARM    8'h66
`define SFM_OP_RST_DO     8'h99
// Geometry in bytes
`define SFM_ARRAY_TOP     24'h1FFFFF
`define SFM_PAGE_MASK     24'hFFFF00
`define SFM_SECT_BYTES    24'h001000
`define SFM_SECT_MASK     24'hFFF000
`define SFM_B32_BYTES     24'h008000
`define SFM_B32_MASK      24'hFF8000
`define SFM_B64_BYTES     24'h010000
`define SFM_B64_MASK      24'hFF0000
// Phase lengths in bits, dummy phases in clocks
`define SFM_CMD_BITS      5'h08
`define SFM_ADDR_BITS     5'h18
`define SFM_BYTE_BITS     5'h08
`define SFM_DUMMY_FAST    5'h08
`define SFM_DUMMY_DUAL_IO 5'h04
`define SFM_DUMMY_QUAD_IO 5'h06
// Reset values
`define SFM_RST_LATCH     1'h0
`define SFM_RST_FOUR_WIRE 1'h0
`define SFM_RST_PWR_DOWN  1'h0
`endif

// ### rtl/sfm_pkg.sv
// Types shared by the flash front end modules.
// Constants live in sfm_cfg.svh.
package sfm_pkg;
  typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_DUMMY, PH_DIN, PH_OUT, PH_IGNORE} sfm_phase_e;
  typedef logic [2:0]  sfm_lanes_t;
  typedef logic [23:0] sfm_addr_t;
endpackage : sfm_pkg

// ### rtl/sfm_stream_if.sv
// Valid/ready byte stream between the front end and its FIFO.
// Both ends run on the same clock.
`timescale 1ns/1ps
interface sfm_stream_if #(
  parameter int W = 8
);
  logic         wvalid;
  logic         wready;
  logic [W-1:0] wdata;
  logic         rvalid;
  logic         rready;
  logic [W-1:0] rdata;
  modport fill_side (output wvalid, output wdata, input wready,
                     input rvalid, input rdata, output rready);
  modport fifo_side (input wvalid, input wdata, output wready,
                     output rvalid, output rdata, input rready);
endinterface : sfm_stream_if

// ### rtl/sfm_fifo.sv
// Program data FIFO with registered read stage.
// Assumes one clock and an active low asynchronous reset.
`timescale 1ns/1ps
module sfm_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  sfm_stream_if.fifo_side s
);
  localparam int AW = $clog2(D);

  // Pointers wrap by width, so only powers of two are served
  if (D < 2 || (D & (D - 1)) != 0) begin : g_chk
    $error("sfm_fifo depth must be a power of two, at least 2");
  end

  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          rvalid_q;
  logic [W-1:0]  rdata_q;
  logic          push;
  logic          pop;

  // Full refuses; the read register refills whenever drained
  assign s.wready = (cnt_q != (AW+1)'(D));
  assign push     = s.wvalid & s.wready;
  assign pop      = (cnt_q != '0) & (!rvalid_q | s.rready);
  assign s.rvalid = rvalid_q;
  assign s.rdata  = rdata_q;

  // Storage array, no reset needed
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wp_q] <= s.wdata;
  end

  // Pointers and fill count
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push)
        wp_q <= wp_q + AW'(1);
      if (pop)
        rp_q <= rp_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Output register
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
    end else if (pop) begin
      rvalid_q <= 1'b1;
      rdata_q  <= mem[rp_q];
    end else if (s.rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule : sfm_fifo

// ### rtl/sfm_front.sv
// Serial flash front end: pin protocol, modes, hold, write latch, protection.
// Assumes pins oversampled by clk_i at four times the serial clock or more;
// status bits and read data come from logic on clk_i.
`timescale 1ns/1ps
`include "sfm_cfg.svh"

// Contract
// - Array of 256B pages, 4K sectors, 32K/64K blocks, ascending.
// - Serial clock modes 0 and 3 both work, idle level free.
// - Inputs sampled on rising serial clock, outputs change on falling.
// - Dual reads use lines 0 and 1, two bits per clock.
// - Quad reads use all four lines, four bits per clock.
// - Quad-width commands execute only while quad enable is one.
// - Enable/disable commands switch four-wire mode; one mode at a time.
// - In four-wire mode the opcode arrives on all four lines.
// - Power-up and software reset leave four-wire mode off.
// - Four-wire mode is honoured only while quad enable is one.
// - Pause works only with quad enable zero; else line 3 is data.
// - Pause stops serial traffic only, not internal operations underway.
// - Pause starts and ends on pin edges, deferred until clock low.
// - While paused, output floats and clock and input are ignored.
// - Chip select rising during pause resets the interface.
// - Write enable command sets the write enable latch.
// - Latch clears on reset, disable, status write, program, any erase.
// - Block protect bits select a readable but unwritable region.
// - Write-protect low locks block protect and status protect bits; here only while status_protect_lo_i is one and quad enable zero.
// - In deep power-down only release and software reset are heard.
// - Fractions 1/32..1/2 at top, or bottom with bit 3.
// - Codes 11x protect all; bit 4 gives 4K..32K at an end.
// - Complement bit inverts the selected region.
// - Latch clear rejects status write, program and erase.
module sfm_front #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        cs_n_i,
  input  wire logic        sclk_i,
  input  wire logic [3:0]  io_i,
  output logic      [3:0]  io_o,
  output logic      [3:0]  io_oe_o,
  input  wire logic        quad_enable_bit_i,
  input  wire logic [4:0]  block_protect_bits_i,
  input  wire logic        complement_protect_bit_i,
  input  wire logic        status_protect_hi_i,
  input  wire logic        status_protect_lo_i,
  input  wire logic [7:0]  rd_data_i,
  output logic      [23:0] rd_addr_o,
  output logic             write_enable_latch_o,
  output logic             four_wire_command_mode_o,
  output logic             deep_power_down_o,
  output logic             hold_active_o,
  output logic             cmd_valid_o,
  output logic      [7:0]  cmd_code_o,
  output logic      [23:0] cmd_addr_o,
  output logic      [15:0] sr_data_o,
  output logic      [7:0]  prog_data_o,
  output logic             prog_valid_o,
  input  wire logic        prog_ready_i,
  output logic             overrun_o
);
  if (FIFO_DEPTH < 2) begin : g_chk
    $error("sfm_front FIFO_DEPTH must be at least 2");
  end

  sfm_pkg::sfm_phase_e ph_q;
  sfm_pkg::sfm_phase_e ph_d;
  sfm_pkg::sfm_lanes_t w;
  sfm_pkg::sfm_addr_t  addr_q;
  logic [2:0]  cs_q;
  logic [2:0]  sclk_q;
  logic [3:0]  io_m_q;
  logic [3:0]  io_s_q;
  logic        hold_q;
  logic        fw_q;
  logic        wel_q;
  logic        dpd_q;
  logic        arm_q;
  logic        prog_ok_q;
  logic        ovr_q;
  logic [7:0]  op_q;
  logic [23:0] sh_q;
  logic [23:0] sh_d;
  logic [4:0]  bit_q;
  logic [4:0]  bits_d;
  logic [4:0]  plen;
  logic        done;
  logic [15:0] sr_q;
  logic [1:0]  sr_cnt_q;
  logic [7:0]  out_sr_q;
  logic [7:0]  out_byte;
  logic [2:0]  ocnt_q;
  logic [3:0]  io_q;
  logic [3:0]  oe_q;
  logic        cv_q;
  logic [7:0]  cc_q;
  logic [23:0] ca_q;
  logic [23:0] rda_q;
  logic        cs_hi;
  logic        cs_rise;
  logic        rise;
  logic        fall;
  logic        fw_on;
  logic        hold_en;
  logic        is_prog;
  logic        sr_lock;
  logic        any_prot;
  logic        exec;

  sfm_stream_if #(.W(8)) prog_if ();

  // Protected-region hit for one address
  function automatic logic prot_hit(input logic [23:0] a, input logic [4:0] bp,
                                    input logic cmp);
    logic [23:0] size;
    logic        hit;
    size = 24'h000000;
    hit  = 1'b0;
    if (bp[2:1] == 2'b11)
      hit = 1'b1;
    else if (bp[2:0] != 3'h0) begin
      if (!bp[4])
        size = `SFM_B64_BYTES << (bp[2:0] - 3'h1);
      else if (bp[2])
        size = `SFM_B32_BYTES;
      else
        size = `SFM_SECT_BYTES << (bp[1:0] - 2'h1);
      if (bp[3])
        hit = (a < size);
      else
        hit = (a > (`SFM_ARRAY_TOP - size));
    end
    return hit ^ cmp;
  endfunction : prot_hit

  // Quad-width opcode test
  function automatic logic is_quad(input logic [7:0] op);
    return (op == `SFM_OP_QUAD_OUT) || (op == `SFM_OP_QUAD_IO) ||
           (op == `SFM_OP_QUAD_PROG);
  endfunction : is_quad

  // Lanes per clock for a phase
  function automatic sfm_pkg::sfm_lanes_t lanes(input sfm_pkg::sfm_phase_e ph,
                                                input logic [7:0] op, input logic fw);
    sfm_pkg::sfm_lanes_t n;
    n = 3'h1;
    if (ph == sfm_pkg::PH_DUMMY)
      n = 3'h1;
    else if (fw)
      n = 3'h4;
    else if (ph == sfm_pkg::PH_ADDR)
      n = (op == `SFM_OP_DUAL_IO) ? 3'h2 : (op == `SFM_OP_QUAD_IO) ? 3'h4 : 3'h1;
    else if (ph != sfm_pkg::PH_CMD) begin
      if (op == `SFM_OP_DUAL_OUT || op == `SFM_OP_DUAL_IO)
        n = 3'h2;
      else if (is_quad(op))
        n = 3'h4;
    end
    return n;
  endfunction : lanes

  // Dummy clocks after the address
  function automatic logic [4:0] dummy_clks(input logic [7:0] op);
    logic [4:0] n;
    n = 5'h00;
    if (op == `SFM_OP_FAST_READ || op == `SFM_OP_DUAL_OUT || op == `SFM_OP_QUAD_OUT)
      n = `SFM_DUMMY_FAST;
    else if (op == `SFM_OP_DUAL_IO)
      n = `SFM_DUMMY_DUAL_IO;
    else if (op == `SFM_OP_QUAD_IO)
      n = `SFM_DUMMY_QUAD_IO;
    return n;
  endfunction : dummy_clks

  // Two-flop synchronisers, third stage only for edge detection
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i) begin
      cs_q   <= 3'h7;
      sclk_q <= 3'h0;
      io_m_q <= 4'hF;
      io_s_q <= 4'hF;
    end else begin
      cs_q   <= {cs_q[1:0], cs_n_i};
      sclk_q <= {sclk_q[1:0], sclk_i};
      io_m_q <= io_i;
      io_s_q <= io_m_q;
    end
  end

  // Either idle level works: only edges inside a frame count
  assign cs_hi   = cs_q[1];
  assign cs_rise = cs_q[1] & ~cs_q[2];
  assign rise    = ~cs_hi & ~hold_q & sclk_q[1] & ~sclk_q[2];
  assign fall    = ~cs_hi & ~hold_q & ~sclk_q[1] & sclk_q[2];
  assign fw_on   = fw_q & quad_enable_bit_i;
  assign hold_en = ~quad_enable_bit_i & ~fw_on;
  assign is_prog = (op_q == `SFM_OP_PAGE_PROG) || (op_q == `SFM_OP_QUAD_PROG);
  assign sr_lock = status_protect_hi_i | (status_protect_lo_i & ~io_s_q[2] & hold_en);
  assign any_prot = prot_hit(24'h000000, block_protect_bits_i, complement_protect_bit_i) |
                    prot_hit(`SFM_ARRAY_TOP, block_protect_bits_i, complement_protect_bit_i);
  assign exec    = cs_rise & ~hold_q;

  // Pause level; follows line 3 only while the serial clock is low, cleared at once by deselect or quad enable
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      hold_q <= 1'b0;
    else if (cs_hi || !hold_en)
      hold_q <= 1'b0;
    else if (!sclk_q[1])
      hold_q <= ~io_s_q[3];
  end

  // Lane width, shifted word and phase end for this rising edge
  always_comb
  begin
    w = lanes(ph_q, op_q, fw_on);
    case (w)
      3'h4:    sh_d = {sh_q[19:0], io_s_q[3:0]};
      3'h2:    sh_d = {sh_q[21:0], io_s_q[1:0]};
      default: sh_d = {sh_q[22:0], io_s_q[0]};
    endcase
    case (ph_q)
      sfm_pkg::PH_CMD:   plen = `SFM_CMD_BITS;
      sfm_pkg::PH_ADDR:  plen = `SFM_ADDR_BITS;
      sfm_pkg::PH_DUMMY: plen = dummy_clks(op_q);
      default:           plen = `SFM_BYTE_BITS;
    endcase
    bits_d = bit_q + {2'b00, w};
    done   = (bits_d == plen);
  end

  // Next phase once the current one completes
  always_comb
  begin
    ph_d = ph_q;
    case (ph_q)
      sfm_pkg::PH_CMD:
      begin
        ph_d = sfm_pkg::PH_IGNORE;
        if (dpd_q && sh_d[7:0] != `SFM_OP_PWR_UP && sh_d[7:0] != `SFM_OP_RST_ARM &&
            sh_d[7:0] != `SFM_OP_RST_DO)
          ph_d = sfm_pkg::PH_IGNORE;
        else if (is_quad(sh_d[7:0]) && !quad_enable_bit_i)
          ph_d = sfm_pkg::PH_IGNORE;
        else if (sh_d[7:0] == `SFM_OP_STAT_WRITE)
          ph_d = sfm_pkg::PH_DIN;
        else if (sh_d[7:0] inside {`SFM_OP_PAGE_PROG, `SFM_OP_QUAD_PROG, `SFM_OP_SECT_ERASE,
                 `SFM_OP_B32_ERASE, `SFM_OP_B64_ERASE, `SFM_OP_READ, `SFM_OP_FAST_READ,
                 `SFM_OP_DUAL_OUT, `SFM_OP_QUAD_OUT, `SFM_OP_DUAL_IO, `SFM_OP_QUAD_IO})
          ph_d = sfm_pkg::PH_ADDR;
      end
      sfm_pkg::PH_ADDR:
      begin
        if (is_prog)
          ph_d = sfm_pkg::PH_DIN;
        else if (op_q == `SFM_OP_SECT_ERASE || op_q == `SFM_OP_B32_ERASE ||
                 op_q == `SFM_OP_B64_ERASE)
          ph_d = sfm_pkg::PH_IGNORE;
        else if (dummy_clks(op_q) != 5'h00)
          ph_d = sfm_pkg::PH_DUMMY;
        else
          ph_d = sfm_pkg::PH_OUT;
      end
      sfm_pkg::PH_DUMMY: ph_d = sfm_pkg::PH_OUT;
      default:           ph_d = ph_q;
    endcase
  end

  // Phase, bit counter and input shifter; pause simply masks the edges
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i) begin
      ph_q  <= sfm_pkg::PH_CMD;
      bit_q <= 5'h00;
      sh_q  <= 24'h000000;
      op_q  <= `SFM_OP_NONE;
    end else if (cs_hi) begin
      ph_q  <= sfm_pkg::PH_CMD;
      bit_q <= 5'h00;
      op_q  <= `SFM_OP_NONE;
    end else if (rise) begin
      sh_q  <= sh_d;
      bit_q <= done ? 5'h00 : bits_d;
      if (done)
        ph_q <= ph_d;
      if (done && ph_q == sfm_pkg::PH_CMD)
        op_q <= (dpd_q && !(sh_d[7:0] inside {`SFM_OP_PWR_UP, `SFM_OP_RST_ARM, `SFM_OP_RST_DO}))
                || (is_quad(sh_d[7:0]) && !quad_enable_bit_i) ? `SFM_OP_NONE : sh_d[7:0];
    end
  end

  // Address capture, program gate and status data collection
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i) begin
      addr_q    <= 24'h000000;
      prog_ok_q <= 1'b0;
      sr_q      <= 16'h0000;
      sr_cnt_q  <= 2'h0;
    end else if (cs_hi) begin
      prog_ok_q <= 1'b0;
      sr_cnt_q  <= 2'h0;
    end else if (rise && done) begin
      if (ph_q == sfm_pkg::PH_ADDR) begin
        addr_q    <= sh_d;
        prog_ok_q <= is_prog & wel_q &
                     ~prot_hit(sh_d, block_protect_bits_i, complement_protect_bit_i);
      end
      if (ph_q == sfm_pkg::PH_DIN && op_q == `SFM_OP_STAT_WRITE && sr_cnt_q != 2'h2) begin
        sr_q     <= {sr_q[7:0], sh_d[7:0]};
        sr_cnt_q <= sr_cnt_q + 2'h1;
      end
    end
  end

  // Program bytes into the FIFO; a full FIFO drops the byte and flags it
  assign prog_if.wvalid = rise & done & (ph_q == sfm_pkg::PH_DIN) & is_prog & prog_ok_q;
  assign prog_if.wdata  = sh_d[7:0];
  assign prog_if.rready = prog_ready_i;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      ovr_q <= 1'b0;
    else if (cs_q[2] && !cs_q[1])
      ovr_q <= 1'b0; // Cleared as a new frame opens
    else if (prog_if.wvalid && !prog_if.wready)
      ovr_q <= 1'b1;
  end

  sfm_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .s      (prog_if.fifo_side)
  );

  // Write enable latch
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      wel_q <= `SFM_RST_LATCH;
    else if (exec) begin
      case (op_q)
        `SFM_OP_WR_ENABLE:  wel_q <= 1'b1;
        `SFM_OP_WR_DISABLE: wel_q <= 1'b0;
        `SFM_OP_RST_DO:     wel_q <= arm_q ? 1'b0 : wel_q;
        `SFM_OP_STAT_WRITE, `SFM_OP_PAGE_PROG, `SFM_OP_QUAD_PROG, `SFM_OP_SECT_ERASE,
        `SFM_OP_B32_ERASE, `SFM_OP_B64_ERASE, `SFM_OP_CHIP_ER_A, `SFM_OP_CHIP_ER_B:
          wel_q <= 1'b0;
        default: wel_q <= wel_q;
      endcase
    end
  end

  // Four-wire mode, deep power-down and the two-step reset
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i) begin
      fw_q  <= `SFM_RST_FOUR_WIRE;
      dpd_q <= `SFM_RST_PWR_DOWN;
      arm_q <= 1'b0;
    end else if (exec && op_q != `SFM_OP_NONE) begin
      arm_q <= (op_q == `SFM_OP_RST_ARM);
      case (op_q)
        `SFM_OP_FOUR_ON:  fw_q <= quad_enable_bit_i;
        `SFM_OP_FOUR_OFF: fw_q <= 1'b0;
        `SFM_OP_PWR_DOWN: dpd_q <= 1'b1;
        `SFM_OP_PWR_UP:   dpd_q <= 1'b0;
        `SFM_OP_RST_DO:
        begin
          if (arm_q) begin
            fw_q  <= 1'b0;
            dpd_q <= 1'b0;
          end
        end
        default: fw_q <= fw_q;
      endcase
    end
  end

  // Accepted write-type commands to the array side; runs on through pause
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i) begin
      cv_q <= 1'b0;
      cc_q <= `SFM_OP_NONE;
      ca_q <= 24'h000000;
    end else begin
      cv_q <= 1'b0;
      if (rise && done && ph_q == sfm_pkg::PH_ADDR && is_prog && wel_q &&
          !prot_hit(sh_d, block_protect_bits_i, complement_protect_bit_i)) begin
        cv_q <= 1'b1;
        cc_q <= op_q;
        ca_q <= sh_d & `SFM_PAGE_MASK;
      end else if (exec && wel_q) begin
        cc_q <= op_q;
        case (op_q)
          `SFM_OP_SECT_ERASE, `SFM_OP_B32_ERASE, `SFM_OP_B64_ERASE:
          begin
            cv_q <= (ph_q == sfm_pkg::PH_IGNORE) &
                    ~prot_hit(addr_q, block_protect_bits_i, complement_protect_bit_i);
            ca_q <= addr_q & ((op_q == `SFM_OP_SECT_ERASE) ? `SFM_SECT_MASK :
                    (op_q == `SFM_OP_B32_ERASE) ? `SFM_B32_MASK : `SFM_B64_MASK);
          end
          `SFM_OP_CHIP_ER_A, `SFM_OP_CHIP_ER_B:
          begin
            cv_q <= ~any_prot;
            ca_q <= 24'h000000;
          end
          `SFM_OP_STAT_WRITE: cv_q <= (sr_cnt_q != 2'h0) & ~sr_lock;
          default: cv_q <= 1'b0;
        endcase
      end
    end
  end

  // Outgoing byte: fresh from the array at a byte boundary
  assign out_byte = (ocnt_q == 3'h0) ? rd_data_i : out_sr_q;

  // Output shifter, changes on the falling serial clock
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i) begin
      ocnt_q   <= 3'h0;
      out_sr_q <= 8'h00;
      io_q     <= 4'h0;
      rda_q    <= 24'h000000;
    end else if (ph_q != sfm_pkg::PH_OUT) begin
      ocnt_q <= 3'h0;
      if (ph_q == sfm_pkg::PH_ADDR)
        rda_q <= sh_d;
    end else if (fall) begin
      ocnt_q   <= ocnt_q + w;
      out_sr_q <= out_byte << w;
      if (ocnt_q == 3'h0)
        rda_q <= rda_q + 24'h000001;
      case (w)
        3'h4:    io_q <= out_byte[7:4];
        3'h2:    io_q <= {2'b00, out_byte[7:6]};
        default: io_q <= {2'b00, out_byte[7], 1'b0};
      endcase
    end
  end

  // Drive enables; released in pause and between frames
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      oe_q <= 4'h0;
    else if (cs_hi || hold_q || ph_q != sfm_pkg::PH_OUT)
      oe_q <= 4'h0;
    else
      oe_q <= (w == 3'h4) ? 4'hF : (w == 3'h2) ? 4'h3 : 4'h2;
  end

  assign io_o                     = io_q;
  assign io_oe_o                  = oe_q;
  assign rd_addr_o                = rda_q;
  assign write_enable_latch_o     = wel_q;
  assign four_wire_command_mode_o = fw_q;
  assign deep_power_down_o        = dpd_q;
  assign hold_active_o            = hold_q;
  assign cmd_valid_o              = cv_q;
  assign cmd_code_o               = cc_q;
  assign cmd_addr_o               = ca_q;
  assign sr_data_o                = sr_q;
  assign prog_data_o              = prog_if.rdata;
  assign prog_valid_o             = prog_if.rvalid;
  assign overrun_o                = ovr_q;
endmodule : sfm_front

// ### sim/sfm_front_assertions.sv
// Port checker for the flash front end, bound into sfm_front.
// Assumes the single clock clk_i and active low nrst_i.
`timescale 1ns/1ps
module sfm_front_assertions (
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        cs_n_i,
  input wire logic [3:0]  io_oe_o,
  input wire logic        quad_enable_bit_i,
  input wire logic [4:0]  block_protect_bits_i,
  input wire logic        complement_protect_bit_i,
  input wire logic        write_enable_latch_o,
  input wire logic        four_wire_command_mode_o,
  input wire logic        deep_power_down_o,
  input wire logic        hold_active_o,
  input wire logic        cmd_valid_o,
  input wire logic [7:0]  cmd_code_o,
  input wire logic [23:0] cmd_addr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Command port, mode and power-down guards
  a_prog_needs_latch:
    assert property (cmd_valid_o && cmd_code_o == 8'h02 |-> write_enable_latch_o)
    else $error("program issued with latch clear");
  a_page_aligned:
    assert property (cmd_valid_o && cmd_code_o == 8'h02 |-> cmd_addr_o[7:0] == 8'h00)
    else $error("program address not page aligned");
  a_sector_aligned:
    assert property (cmd_valid_o && cmd_code_o == 8'h20 |-> cmd_addr_o[11:0] == 12'h000)
    else $error("erase address not sector aligned");
  a_top_guarded:
    assert property (cmd_valid_o && block_protect_bits_i == 5'h01 && !complement_protect_bit_i
      |-> cmd_addr_o < 24'h1F0000)
    else $error("write into upper 1/32");
  a_all_guarded:
    assert property (!(cmd_valid_o && cmd_code_o != 8'h01 && !complement_protect_bit_i
      && block_protect_bits_i[2:1] == 2'h3))
    else $error("write with whole array protected");
  a_mode_needs_qe:
    assert property ($rose(four_wire_command_mode_o) |-> quad_enable_bit_i)
    else $error("four-wire mode without quad enable");
  a_sleep_deaf:
    assert property (deep_power_down_o && $past(deep_power_down_o) |-> !$rose(write_enable_latch_o))
    else $error("latch set in deep power-down");
  // Pause guards
  a_hold_qe_only:
    assert property (hold_active_o |-> !quad_enable_bit_i && !four_wire_command_mode_o)
    else $error("pause with quad enable set");
  a_hold_floats:
    assert property (hold_active_o && $past(hold_active_o) |-> io_oe_o == 4'h0)
    else $error("output driven while paused");
  a_cs_ends_hold:
    assert property (cs_n_i [*4] |-> !hold_active_o)
    else $error("pause kept after deselect");
endmodule : sfm_front_assertions

bind sfm_front sfm_front_assertions u_chk (.clk_i, .nrst_i, .cs_n_i, .io_oe_o,
  .quad_enable_bit_i, .block_protect_bits_i, .complement_protect_bit_i, .write_enable_latch_o,
  .four_wire_command_mode_o, .deep_power_down_o, .hold_active_o, .cmd_valid_o, .cmd_code_o,
  .cmd_addr_o);

// ### sim/sfm_host_model.sv
// Host serial controller model: mode 0 frames, MSB first.
// Assumes clk_i at 10 MHz; each serial half period is three clocks.
`timescale 1ns/1ps
module sfm_host_model (
  input  wire logic       clk_i,
  output logic            cs_n,
  output logic            sclk,
  output logic [3:0]      io
);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    io   = 4'hF;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wt
  // Bits set while sclk low, taken by the rising edge; q sends nibbles
  task automatic put(input logic [7:0] b, input bit q);
    for (int i = 7; i >= 0; i -= (q ? 4 : 1))
    begin
      if (q) io = b[i-:4];
      else io[0] = b[i];
      wt(3);
      sclk = 1'b1;
      wt(3);
      sclk = 1'b0;
    end
  endtask : put
  // Whole frame: opcode, na address bytes, nd data bytes counting up
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int na,
                       input int nd, input bit q);
    cs_n = 1'b0;
    wt(4);
    put(op, q);
    for (int k = na - 1; k >= 0; k--) put(a[8*k+:8], 1'b0);
    for (int k = 0; k < nd; k++) put(8'(k), 1'b0);
    wt(3);
    cs_n = 1'b1;
    io   = ~io; // Released lines do not keep the last value
    wt(6);
    io   = 4'hF;
  endtask : frame
endmodule : sfm_host_model

// ### sim/sfm_front_bench.sv
// Self-checking bench for sfm_front with the host model on its pins.
// Assumes the checker is bound in; all scenarios run in sequence.
`timescale 1ns/1ps
module sfm_front_bench;
  logic clk_i = 1'b0, nrst_i = 1'b0, qe = 1'b0, cmp = 1'b0, rdy = 1'b0, lk = 1'b0;
  logic [4:0] bp = 5'h00;
  logic cs_n, sclk;
  logic [3:0] h_io, io_o, io_oe_o;
  logic write_enable_latch, fw, pd, hold, cv, pv, ovr;
  logic [7:0] code, pdat;
  logic [23:0] addr, ra;
  logic [15:0] sr;
  int err_total = 0, compares = 0, ncmd = 0, pops = 0;
  logic [7:0] lcode;
  logic [23:0] laddr;
  wire [3:0] io_w = (io_oe_o & io_o) | (~io_oe_o & h_io);
  always #50 clk_i = ~clk_i;
  sfm_host_model u_host (.clk_i(clk_i), .cs_n(cs_n), .sclk(sclk), .io(h_io));
  sfm_front u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n), .sclk_i(sclk),
    .io_i(io_w), .io_o(io_o), .io_oe_o(io_oe_o), .quad_enable_bit_i(qe),
    .block_protect_bits_i(bp), .complement_protect_bit_i(cmp), .status_protect_hi_i(lk),
    .status_protect_lo_i(lk), .rd_data_i(ra[7:0]), .rd_addr_o(ra), .write_enable_latch_o(write_enable_latch),
    .four_wire_command_mode_o(fw), .deep_power_down_o(pd), .hold_active_o(hold),
    .cmd_valid_o(cv), .cmd_code_o(code), .cmd_addr_o(addr), .sr_data_o(sr),
    .prog_data_o(pdat), .prog_valid_o(pv), .prog_ready_i(rdy), .overrun_o(ovr));
  // Command and pop monitor
  always @(posedge clk_i)
  begin
    if (cv === 1'b1)
    begin
      ncmd++;
      lcode = code;
      laddr = addr;
    end
    if (pv === 1'b1 && rdy === 1'b1) pops++;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    if (err_total == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic t_latch();
    check({write_enable_latch, fw, pd, cv, pv}, 0);
    u_host.frame(8'h06, 0, 0, 0, 0);
    check(write_enable_latch, 1);
    u_host.frame(8'h04, 0, 0, 0, 0);
    check(write_enable_latch, 0);
    u_host.frame(8'h03, 24'h0000C0, 3, 1, 0);
    check({ra, io_o}, {24'h0000C2, 4'h2});
  endtask : t_latch
  // Program: refused, then FIFO overfilled
  task automatic t_prog();
    u_host.frame(8'h02, 24'h000123, 3, 1, 0);
    check(ncmd, 0);
    u_host.frame(8'h06, 0, 0, 0, 0);
    u_host.frame(8'h02, 24'h000123, 3, 20, 0);
    check({ncmd, lcode, laddr}, {32'd1, 8'h02, 24'h000100});
    check({write_enable_latch, ovr}, 2'b01);
    rdy = 1'b1;
    u_host.wt(40);
    check(pops >= 16, 1);
    check({pv, pdat}, 9'h010);
  endtask : t_prog
  // Erase vs protection: {bp, cmp, addr, issued}
  task automatic t_erase();
    logic [30:0] tb [4] = '{{5'h01, 1'b0, 24'h1F0000, 1'b0}, {5'h01, 1'b0, 24'h1EF123, 1'b1},
      {5'h06, 1'b0, 24'h000000, 1'b0}, {5'h01, 1'b1, 24'h1F0000, 1'b1}};
    foreach (tb[i])
    begin
      {bp, cmp} = tb[i][30:25];
      ncmd = 0;
      u_host.frame(8'h06, 0, 0, 0, 0);
      u_host.frame(8'h20, tb[i][24:1], 3, 0, 0);
      check(ncmd, tb[i][0]);
      if (tb[i][0]) check(laddr, tb[i][24:1] & 24'hFFF000);
    end
    {bp, cmp} = 6'h00;
  endtask : t_erase
  task automatic t_modes();
    u_host.frame(8'h38, 0, 0, 0, 0);
    check(fw, 0);
    qe = 1'b1;
    u_host.frame(8'h38, 0, 0, 0, 0);
    check(fw, 1);
    u_host.frame(8'hFF, 0, 0, 0, 1);
    check(fw, 0);
    qe = 1'b0;
    u_host.frame(8'hB9, 0, 0, 0, 0);
    u_host.frame(8'h06, 0, 0, 0, 0);
    check({pd, write_enable_latch}, 2'b10);
    u_host.frame(8'hAB, 0, 0, 0, 0);
    check(pd, 0);
    repeat (2)
    begin
      u_host.frame(8'h06, 0, 0, 0, 0);
      u_host.frame(8'h01, 0, 0, 2, 0);
      lk = 1'b1;
    end
    check({ncmd, sr}, {32'd2, 16'h0001});
  endtask : t_modes
  // Pause, then deselect while paused
  task automatic t_hold();
    u_host.cs_n = 1'b0;
    u_host.io[3] = 1'b0;
    u_host.wt(8);
    check({hold, io_oe_o}, 5'h10);
    u_host.cs_n = 1'b1;
    u_host.wt(6);
    check(hold, 0);
    u_host.io[3] = 1'b1;
    u_host.wt(6);
  endtask : t_hold
  initial
  begin
    u_host.wt(20);
    nrst_i = 1'b1;
    u_host.wt(2);
    t_latch();
    t_prog();
    t_erase();
    t_modes();
    t_hold();
    wrap_up();
  end
  // Watchdog: a run needs about 0.4 ms
  initial
  begin
    #2000000;
    err_total++;
    wrap_up();
  end
endmodule : sfm_front_bench
